// [rtl/dcil_top.sv]
// Daisy chain interrupt logic of a dual channel serial controller
// What this block does
// R1 - Drive active low interrupt request
// R2 - Acknowledge is opcode fetch with io request
// R3 - Top chain input tied high externally
// R4 - Idle device passes chain enable through
// R5 - Pending or serviced device blocks chain
// R6 - Status frozen while opcode fetch low
// R7 - Enabled requester drives vector, sets latch
// R8 - Watch fetched opcodes for return sequence
// R9 - After prefix, unacknowledged sources pass chain
// R10 - Return opcode clears serviced latch
// R11 - Software return command clears latch too
// R12 - Six internal sources, fixed priority
// R13 - Higher source nests over lower service
// R14 - Return byte on addressed input cycle
// R15 - Accept byte on addressed output cycle
// R16 - Request only when nothing above serviced
`timescale 1ns/1ns
module dcil_top
  import dcil_pkg::*;
#(
  parameter int unsigned N = DCIL_NUM_SRC
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_rst_b,
  input  wire logic         i_opcode_fetch_n,
  input  wire logic         i_io_request_n,
  input  wire logic         i_read_n,
  input  wire logic         i_write_n,
  input  wire logic         i_chip_select_n,
  input  wire logic         i_chain_enable_in,
  input  wire logic [7:0]   i_data,
  input  wire logic [N-1:0] i_src_pending,
  input  wire logic [8*N-1:0] i_src_vector,
  input  wire logic [7:0]   i_read_byte,
  input  wire logic         i_sw_return,
  output logic              o_int_request_n,
  output logic              o_chain_enable_out,
  output logic [7:0]        o_data,
  output logic              o_data_oe,
  output logic [N-1:0]      o_ack_pulse,
  output logic [N-1:0]      o_in_service,
  output logic [7:0]        o_write_byte,
  output logic              o_write_strobe,
  output logic              o_read_strobe
);
  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [5:0] pin_s;
  logic       fetch_n;
  logic       io_request_n_n;
  logic       rd_n;
  logic       wr_n;
  logic       cs_n;
  logic       cei;
  logic [7:0] data_s;
  dcil_sync #(.W(6), .RST_VAL(6'h3F)) u_sync_ctl (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_async    ({i_opcode_fetch_n, i_io_request_n, i_read_n,
                  i_write_n, i_chip_select_n, i_chain_enable_in}),
    .o_sync     (pin_s)
  );
  dcil_sync #(.W(8), .RST_VAL(8'h00)) u_sync_dat (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_async    (i_data),
    .o_sync     (data_s)
  );
  assign {fetch_n, io_request_n_n, rd_n, wr_n, cs_n, cei} = pin_s;
  ////////////////////////////////////////////////////////////////////
  // State
  typedef enum logic [1:0] {OP_IDLE, OP_PREFIX} dcil_op_t;
  typedef struct packed {
    logic [N-1:0] pend;
    logic [N-1:0] ius;
    dcil_op_t     op;
    logic         fetch_n_p;
    logic         io_request_n_n_p;
    logic         ack_done;
    logic [7:0]   dout;
    logic         doe;
    logic [N-1:0] ack;
    logic [7:0]   wbyte;
    logic         wstb;
    logic         rstb;
    logic         irq_n;
  } dcil_st_t;
  dcil_st_t st_q;
  dcil_st_t st_d;
  logic [N-1:0] grant;
  logic [N-1:0] serviced;
  logic         ceo;
  logic         prefix;
  assign prefix = (st_q.op == OP_PREFIX);
  dcil_chain #(.N(N)) u_chain (
    .i_enable      (cei),
    .i_pending     (st_q.pend),
    .i_in_service  (st_q.ius),
    .i_prefix_seen (prefix),
    .o_grant       (grant),
    .o_serviced    (serviced),
    .o_enable_out  (ceo)
  );
  function automatic logic [N-1:0] lowest_one(input logic [N-1:0] v);
    logic [N-1:0] r;
    r = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = '0;
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction
  ////////////////////////////////////////////////////////////////////
  // Next state
  logic fetch_rise;
  logic io_request_n_fall;
  logic wr_fall;
  logic rd_fall;
  logic [N-1:0] first_grant;
  logic [N-1:0] clr;
  assign fetch_rise  = fetch_n && !st_q.fetch_n_p;
  assign io_request_n_fall   = !io_request_n_n && st_q.io_request_n_n_p;
  assign wr_fall     = !wr_n && !cs_n && fetch_n && io_request_n_fall;
  assign rd_fall     = !rd_n && !cs_n && fetch_n && io_request_n_fall;
  assign first_grant = lowest_one(grant);
  always_comb begin
    st_d           = st_q;
    st_d.fetch_n_p = fetch_n;
    st_d.io_request_n_n_p  = io_request_n_n;
    st_d.ack       = '0;
    st_d.wstb      = 1'b0;
    st_d.rstb      = 1'b0;
    clr            = '0;
    // R6 freeze status during fetch
    if (fetch_n) begin
      st_d.pend = i_src_pending;
    end
    // R8 opcode monitor on fetch end
    if (fetch_rise && io_request_n_n) begin
      st_d.op = (data_s == DCIL_OP_PREFIX) ? OP_PREFIX : OP_IDLE;
      // R10 clear serviced latch
      if (prefix && data_s == DCIL_OP_RETURN) begin
        clr = serviced;
      end
    end
    // R11 software return command
    if (i_sw_return) begin
      clr = clr | lowest_one(st_q.ius);
    end
    // R13 clear highest only, lower resumes
    st_d.ius = st_q.ius & ~clr;
    // R2 acknowledge is fetch plus io_request_n
    if (!fetch_n && io_request_n_fall && !st_q.ack_done) begin
      st_d.ack_done = 1'b1;
      // R7 vector out and latch set
      if (|first_grant) begin
        st_d.ius = st_d.ius | first_grant;
        st_d.ack = first_grant;
        st_d.doe = 1'b1;
        for (int i = 0; i < N; i++) begin
          if (first_grant[i]) begin
            st_d.dout = i_src_vector[8*i +: 8];
          end
        end
      end
    end
    // R14 input cycle returns byte
    if (rd_fall) begin
      st_d.dout = i_read_byte;
      st_d.doe  = 1'b1;
      st_d.rstb = 1'b1;
    end
    // R15 output cycle takes byte
    if (wr_fall) begin
      st_d.wbyte = data_s;
      st_d.wstb  = 1'b1;
    end
    if (io_request_n_n) begin
      st_d.doe      = 1'b0;
      st_d.ack_done = 1'b0;
    end
    // R16 request only below no service
    // R1 active low request
    st_d.irq_n = ~(|grant);
  end
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= '{pend: DCIL_SRC_RST, ius: DCIL_SRC_RST, op: OP_IDLE,
                fetch_n_p: 1'b1, io_request_n_n_p: 1'b1, ack_done: 1'b0,
                dout: DCIL_DATA_RST, doe: 1'b0, ack: '0,
                wbyte: DCIL_DATA_RST, wstb: 1'b0, rstb: 1'b0,
                irq_n: 1'b1};
    end else begin
      st_q <= st_d;
    end
  end
  ////////////////////////////////////////////////////////////////////
  // Outputs
  // R4 R5 chain out from internal chain
  assign o_chain_enable_out = ceo;
  assign o_int_request_n    = st_q.irq_n;
  assign o_data             = st_q.dout;
  assign o_data_oe          = st_q.doe;
  assign o_ack_pulse        = st_q.ack;
  assign o_in_service       = st_q.ius;
  assign o_write_byte       = st_q.wbyte;
  assign o_write_strobe     = st_q.wstb;
  assign o_read_strobe      = st_q.rstb;
  ////////////////////////////////////////////////////////////////////
  // Checks
  // R5 serviced source blocks chain
  ius_blocks_a: assert property ( // R5
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (|st_q.ius) |-> !o_chain_enable_out)
    else $error("chain not blocked");
  // R4 idle device passes chain
  idle_pass_a: assert property ( // R4
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (st_q.ius == '0 && st_q.pend == '0) |-> o_chain_enable_out == cei)
    else $error("chain not passed");
  // R1 request follows grant
  irq_drive_a: assert property ( // R1
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (|grant) |=> !o_int_request_n)
    else $error("request missing");
  // R16 no request under service above
  irq_block_a: assert property ( // R16
    @(posedge i_core_clk) disable iff (!i_rst_b)
    !cei |=> o_int_request_n)
    else $error("request while blocked");
  // R6 pending frozen during fetch
  freeze_pend_a: assert property ( // R6
    @(posedge i_core_clk) disable iff (!i_rst_b)
    !fetch_n |=> $stable(st_q.pend))
    else $error("status moved");
  // R7 acknowledge sets latch
  ack_latch_a: assert property ( // R7
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (|st_q.ack) |-> ((st_q.ack & st_q.ius) == st_q.ack && o_data_oe))
    else $error("latch not set");
  // R10 return opcode clears latch
  ret_clear_a: assert property ( // R10
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (fetch_rise && io_request_n_n && prefix && data_s == DCIL_OP_RETURN
     && |serviced) |=> (st_q.ius & $past(serviced)) == '0)
    else $error("latch not cleared");
  // R15 write strobe carries byte
  write_take_a: assert property ( // R15
    @(posedge i_core_clk) disable iff (!i_rst_b)
    wr_fall |=> o_write_strobe && o_write_byte == $past(data_s))
    else $error("write lost");
  // R5 pending source blocks chain
  pend_blocks_a: assert property ( // R5
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (!prefix && (|st_q.pend)) |-> !o_chain_enable_out)
    else $error("pending not blocking");
  // R9 prefix passes unacknowledged sources
  prefix_pass_a: assert property ( // R9
    @(posedge i_core_clk) disable iff (!i_rst_b)
    prefix |-> o_chain_enable_out == (cei && st_q.ius == '0))
    else $error("prefix chain wrong");
  // R1 no request without grant
  irq_idle_a: assert property ( // R1
    @(posedge i_core_clk) disable iff (!i_rst_b)
    !(|grant) |=> o_int_request_n)
    else $error("request without grant");
  // R12 one source per acknowledge
  ack_onehot_a: assert property ( // R12
    @(posedge i_core_clk) disable iff (!i_rst_b)
    $onehot0(st_q.ack))
    else $error("several sources acknowledged");
  // R7 acknowledge needs chain enable
  ack_enable_a: assert property ( // R7
    @(posedge i_core_clk) disable iff (!i_rst_b)
    !cei |=> st_q.ack == '0)
    else $error("acknowledged while disabled");
  // R7 bus released after cycle
  bus_release_a: assert property ( // R7
    @(posedge i_core_clk) disable iff (!i_rst_b)
    io_request_n_n |=> !o_data_oe)
    else $error("bus held too long");
  // R14 input cycle returns byte
  read_give_a: assert property ( // R14
    @(posedge i_core_clk) disable iff (!i_rst_b)
    rd_fall |=> o_read_strobe && o_data_oe && o_data == $past(i_read_byte))
    else $error("read byte lost");
  // R11 software return clears latch
  sw_clear_a: assert property ( // R11
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (i_sw_return && fetch_n)
    |=> (st_q.ius & lowest_one($past(st_q.ius))) == '0)
    else $error("software return ignored");
  // R6 service latches frozen in fetch
  ius_frozen_a: assert property ( // R6
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (!fetch_n && !io_request_n_fall && !i_sw_return) |=> $stable(st_q.ius))
    else $error("service latch moved");
  // R10 clear only on return
  clear_cause_a: assert property ( // R10
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (|(st_q.ius & ~st_d.ius)) |-> (i_sw_return || (fetch_rise && io_request_n_n
      && prefix && data_s == DCIL_OP_RETURN)))
    else $error("latch cleared without return");
  // R8 prefix byte arms monitor
  prefix_arm_a: assert property ( // R8
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (fetch_rise && io_request_n_n && data_s == DCIL_OP_PREFIX) |=> prefix)
    else $error("prefix not seen");
endmodule // dcil_top

// [rtl/dcil_pkg.sv]
// Constants for the daisy chain interrupt logic
package dcil_pkg;
  localparam int unsigned    DCIL_NUM_SRC     = 6;
  localparam logic [7:0]     DCIL_OP_PREFIX   = 8'hED;
  localparam logic [7:0]     DCIL_OP_RETURN   = 8'h4D;
  localparam logic [7:0]     DCIL_VEC_RST     = 8'h00;
  localparam logic [7:0]     DCIL_DATA_RST    = 8'h00;
  localparam logic [5:0]     DCIL_SRC_RST     = 6'h00;
endpackage : dcil_pkg

// [rtl/dcil_sync.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module dcil_sync
  import dcil_pkg::*;
#(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_rst_b,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] out;
  } dcil_sync_t;
  dcil_sync_t st_q;
  dcil_sync_t st_d;
  always_comb begin
    st_d     = st_q;
    st_d.s1  = i_async;
    st_d.s2  = st_q.s1;
    st_d.s3  = st_q.s2;
    for (int i = 0; i < W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.out[i] = st_q.s2[i];
      end
    end
  end
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, out: RST_VAL};
    end else begin
      st_q <= st_d;
    end
  end
  assign o_sync = st_q.out;
endmodule // dcil_sync

// [rtl/dcil_chain.sv]
// Internal six level priority chain, combinational
`timescale 1ns/1ns
module dcil_chain
  import dcil_pkg::*;
#(
  parameter int unsigned N = DCIL_NUM_SRC
) (
  input  wire logic         i_enable,
  input  wire logic [N-1:0] i_pending,
  input  wire logic [N-1:0] i_in_service,
  input  wire logic         i_prefix_seen,
  output logic      [N-1:0] o_grant,
  output logic      [N-1:0] o_serviced,
  output logic              o_enable_out
);
  // R12 fixed priority chain, bit 0 highest
  always_comb begin
    logic en;
    en         = i_enable;
    o_grant    = '0;
    o_serviced = '0;
    for (int i = 0; i < N; i++) begin
      o_grant[i]    = en && i_pending[i] && !i_in_service[i];
      o_serviced[i] = en && i_in_service[i];
      // R9 pending ignored after prefix
      if (i_in_service[i] || (i_pending[i] && !i_prefix_seen)) begin
        en = 1'b0;
      end
    end
    o_enable_out = en;
  end
endmodule // dcil_chain

// [tb/dcil_cpu.sv]
// Host processor bus model for the interrupt chain
`timescale 1ns/1ns
module dcil_cpu (
  input  wire logic       i_core_clk,
  input  wire logic [7:0] i_dev_data,
  input  wire logic       i_dev_oe,
  output logic            o_opcode_fetch_n,
  output logic            o_io_request_n,
  output logic            o_read_n,
  output logic            o_write_n,
  output logic            o_chip_select_n,
  output logic            o_chain_enable_in,
  output logic [7:0]      o_bus
);
  logic       drv;
  logic [7:0] d;
  initial begin
    drv = 1'b0;
    d = 8'h00;
    {o_opcode_fetch_n, o_io_request_n, o_read_n, o_write_n} = 4'hF;
    o_chip_select_n = 1'b1;
    o_chain_enable_in = 1'b1;
  end
  // Released bus shows inverse of last byte
  assign o_bus = i_dev_oe ? i_dev_data : (drv ? d : ~d);
  task automatic chain(input logic v);
    o_chain_enable_in <= v;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task automatic fetch(input logic [7:0] op, input int hold);
    d <= op;
    drv <= 1'b1;
    o_opcode_fetch_n <= 1'b0;
    cyc(hold);
    o_opcode_fetch_n <= 1'b1;
    cyc(6);
    drv <= 1'b0;
    cyc(2);
  endtask
  task automatic ack(input int lag, output bit ok);
    int k;
    o_opcode_fetch_n <= 1'b0;
    cyc(lag);
    o_io_request_n <= 1'b0;
    for (k = 0; k < 20 && i_dev_oe !== 1'b1; k++) cyc(1);
    ok = (k < 20);
    cyc(1);
    o_opcode_fetch_n <= 1'b1;
    o_io_request_n <= 1'b1;
    cyc(8);
  endtask
  task automatic io(input bit wr, input logic [7:0] v);
    o_chip_select_n <= 1'b0;
    d <= v;
    drv <= wr;
    o_write_n <= ~wr;
    o_read_n <= wr;
    cyc(1);
    o_io_request_n <= 1'b0;
    cyc(8);
    {o_io_request_n, o_chip_select_n, o_read_n, o_write_n} <= 4'hF;
    cyc(2);
    drv <= 1'b0;
    cyc(4);
  endtask
endmodule // dcil_cpu

// [tb/tb_top.sv]
// Self-checking bench for the daisy chain interrupt logic
`timescale 1ns/1ns
module tb_top
  import dcil_pkg::*;
;
  localparam int N = DCIL_NUM_SRC;
  logic           i_core_clk, i_rst_b, swr, fn, rq, rdn, wrn, csn, cei;
  logic           irq_n, ceo, oe, wstb, rstb;
  logic [N-1:0]   pend, ackp, insv;
  logic [8*N-1:0] vec;
  logic [7:0]     rbyte, bus, dout, wbyte;
  logic [15:0]    exp_q[$];
  int             errors, compares, i, k;
  bit             ok;
  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end
  dcil_top #(.N(N)) dcil_top_inst (.i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b), .i_opcode_fetch_n(fn), .i_io_request_n(rq),
    .i_read_n(rdn), .i_write_n(wrn), .i_chip_select_n(csn),
    .i_chain_enable_in(cei), .i_data(bus), .i_src_pending(pend),
    .i_src_vector(vec), .i_read_byte(rbyte), .i_sw_return(swr),
    .o_int_request_n(irq_n), .o_chain_enable_out(ceo), .o_data(dout),
    .o_data_oe(oe), .o_ack_pulse(ackp), .o_in_service(insv),
    .o_write_byte(wbyte), .o_write_strobe(wstb), .o_read_strobe(rstb));
  dcil_cpu cpu_inst (.i_core_clk(i_core_clk), .i_dev_data(dout),
    .i_dev_oe(oe), .o_opcode_fetch_n(fn), .o_io_request_n(rq),
    .o_read_n(rdn), .o_write_n(wrn), .o_chip_select_n(csn),
    .o_chain_enable_in(cei), .o_bus(bus));
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic ack(input int lag);
    cpu_inst.ack(lag, ok);
    if (!ok) begin
      errors++;
      give_verdict();
    end
  endtask
  task automatic return_from_interrupt();
    cpu_inst.fetch(DCIL_OP_PREFIX, 6);
    cpu_inst.fetch(DCIL_OP_RETURN, 6);
    cyc(2);
  endtask
  // Result monitor takes oldest note
  always @(posedge i_core_clk) begin
    if (i_rst_b === 1'b1 && (|ackp || wstb || rstb)) begin
      if (exp_q.size() == 0) chk('x, {wstb, rstb, ackp, dout});
      else chk(exp_q.pop_front(), {wstb, rstb, ackp, wstb ? wbyte : dout});
    end
  end
  initial begin
    i_rst_b = 1'b0;
    pend = '0;
    swr = 1'b0;
    rbyte = 8'h00;
    void'($urandom(32'h108c_0233));
    for (i = 0; i < N; i++) vec[8*i+:8] = 8'($urandom) & 8'hFE;
    cyc(6);
    i_rst_b <= 1'b1;
    cyc(6);
    chk(16'h0001, 16'(irq_n));
    chk(16'h0001, 16'(ceo));
    for (i = N - 1; i >= 0; i--) begin
      fork
        cpu_inst.fetch(8'h00, 14);
        begin
          cyc(6);
          pend <= N'(1) << i;
          cyc(4);
          chk(16'h0001, 16'(irq_n));
        end
      join
      cyc(3);
      chk(16'h0000, 16'(irq_n));
      chk(16'h0000, 16'(ceo));
      exp_q.push_back({2'b00, N'(1) << i, vec[8*i+:8]});
      ack(5 + 7 * (i % 2));
      pend <= '0;
      chk(16'(N'(1) << i), 16'(insv));
      return_from_interrupt();
      chk(16'h0000, 16'(insv));
      chk(16'h0001, 16'(ceo));
    end
    pend <= 6'h20;
    cyc(6);
    exp_q.push_back({2'b00, 6'h20, vec[47:40]});
    ack(5);
    pend <= 6'h01;
    cyc(6);
    chk(16'h0000, 16'(irq_n));
    exp_q.push_back({2'b00, 6'h01, vec[7:0]});
    ack(12);
    pend <= 6'h08;
    cyc(6);
    chk(16'h0001, 16'(irq_n));
    chk(16'h0021, 16'(insv));
    swr <= 1'b1;
    cyc(1);
    swr <= 1'b0;
    cyc(6);
    chk(16'h0020, 16'(insv));
    chk(16'h0000, 16'(irq_n));
    return_from_interrupt();
    chk(16'h0000, 16'(insv));
    pend <= '0;
    cpu_inst.chain(1'b0);
    cyc(6);
    chk(16'h0000, 16'(ceo));
    cpu_inst.chain(1'b1);
    for (i = 0; i < 4; i++) begin
      k = $urandom;
      rbyte <= 8'($urandom);
      exp_q.push_back({2'b10, 6'h00, 8'(k)});
      cpu_inst.io(1'b1, 8'(k));
      exp_q.push_back({2'b01, 6'h00, rbyte});
      cpu_inst.io(1'b0, 8'h00);
    end
    for (k = 0; k < 50 && exp_q.size() > 0; k++) cyc(1);
    chk(16'h0000, 16'(exp_q.size()));
    give_verdict();
  end
endmodule // tb_top
